// ==== rtl/tbt_top.sv ====
// trace capture trigger logic, fifo and trace ram port with bist access
`include "tbt_params.svh"

module tbt_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  // filling side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // draining side
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      wr_next;
  logic [AW:0]      rd_reg;
  logic [AW:0]      rd_next;
  logic             push;
  logic             pop;

  // full and empty from pointers with wrap bit
  always_comb
  begin
    in_ready_o  = (wr_reg[AW] == rd_reg[AW]) ||
                  (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
    out_valid_o = (wr_reg != rd_reg);
    out_data_o  = mem[rd_reg[AW-1:0]];
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_next     = push ? wr_reg + 1'b1 : wr_reg;
    rd_next     = pop ? rd_reg + 1'b1 : rd_reg;
  end

  // pointer registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  // storage, no reset
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem[wr_reg[AW-1:0]] <= in_data_i;
  end
endmodule

module tbt_top #(
  parameter int ADDR_W     = 10,
  parameter int CNT_W      = 10,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_b_i,
  // incoming trace words
  input  wire tbt_pkg::tbt_word_type trace_i,
  input  wire logic                  trace_valid_i,
  output logic                       trace_ready_o,
  // control
  input  wire tbt_pkg::tbt_format_flush_control_type format_flush_control_i,
  input  wire logic                  capture_enable_i,
  input  wire logic                  trig_count_load_i,
  input  wire logic [CNT_W-1:0]      trig_count_i,
  input  wire logic                  flush_done_i,
  // cross-trigger events
  input  wire logic                  trig_in_i,
  output logic                       trig_event_o,
  output logic                       acq_complete_o,
  output logic                       full_o,
  // status
  output logic                       capture_stopped_o,
  output logic [ADDR_W-1:0]          wr_ptr_o,
  output logic [CNT_W-1:0]           post_count_o,
  // functional readback
  input  wire logic                  rd_en_i,
  input  wire logic [ADDR_W-1:0]     rd_addr_i,
  output logic [31:0]                rd_data_o,
  // memory self-test port
  input  wire logic                  mtest_on_i,
  input  wire logic                  bist_ce_i,
  input  wire logic                  bist_we_i,
  input  wire logic [ADDR_W-1:0]     bist_addr_i,
  input  wire logic [31:0]           bist_din_i,
  output logic [31:0]                bist_dout_o
);
  localparam int WW = $bits(tbt_pkg::tbt_word_type);

  // mode from the two format bits
  function automatic tbt_pkg::tbt_mode_type mode_of(
    input tbt_pkg::tbt_format_flush_control_type c);
    if (!c.frame_format_enable)
      mode_of = tbt_pkg::TBT_BYPASS;
    else if (c.continuous_format_enable)
      mode_of = tbt_pkg::TBT_FRAMED_CONT;
    else
      mode_of = tbt_pkg::TBT_FRAMED;
  endfunction

  // valid low bytes of a word, stray upper lanes cleared
  function automatic logic [31:0] low_bytes(
    input tbt_pkg::tbt_word_type w);
    if (w.valid_bytes == 2'h0)
      low_bytes = w.data;
    else
      low_bytes = w.data & ~(32'hffff_ffff << {w.valid_bytes, 3'h0});
  endfunction

  tbt_pkg::tbt_state_type state_reg;
  tbt_pkg::tbt_state_type state_next;
  tbt_pkg::tbt_mode_type  mode;
  tbt_pkg::tbt_word_type  fifo_word;
  logic [WW-1:0]          fifo_bits;
  logic                   fifo_valid;
  logic                   fifo_pop;
  logic [ADDR_W-1:0]      wp_reg;
  logic [ADDR_W-1:0]      wp_next;
  logic [CNT_W-1:0]       count_reg;
  logic [CNT_W-1:0]       count_next;
  logic                   seen_reg;
  logic                   seen_next;
  logic                   full_reg;
  logic                   full_next;
  logic [2:0]             pend_reg;
  logic [2:0]             pend_next;
  logic [2:0]             pad_reg;
  logic [2:0]             pad_next;
  tbt_pkg::tbt_word_type  hold_reg;
  tbt_pkg::tbt_word_type  hold_next;
  logic                   hold_v_reg;
  logic                   hold_v_next;
  logic                   evt_reg;
  logic                   evt_next;
  logic                   sync1_reg;
  logic                   sync2_reg;
  logic                   sync3_reg;
  logic                   tin_reg;
  logic                   tin_next;
  logic                   tin_rise;
  logic                   f_we;
  logic [31:0]            f_wdata;
  logic                   cnt_hit;
  logic                   stop_req;
  logic [31:0]            ram [2**ADDR_W];
  logic [31:0]            rd_reg;
  logic [31:0]            bist_reg;

  tbt_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (trace_i),
    .in_valid_i  (trace_valid_i),
    .in_ready_o  (trace_ready_o),
    .out_data_o  (fifo_bits),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  // trigger input filter: level changes when stages two and three agree
  always_comb
  begin
    tin_next = (sync2_reg == sync3_reg) ? sync3_reg : tin_reg;
    tin_rise = tin_next && !tin_reg;
  end

  // main capture sequence
  always_comb
  begin
    fifo_word   = tbt_pkg::tbt_word_type'(fifo_bits);
    mode        = mode_of(format_flush_control_i);
    state_next  = state_reg;
    wp_next     = wp_reg;
    count_next  = count_reg;
    seen_next   = seen_reg;
    full_next   = full_reg;
    pad_next    = pad_reg;
    hold_next   = hold_reg;
    hold_v_next = hold_v_reg;
    fifo_pop    = 1'b0;
    f_we        = 1'b0;
    f_wdata     = `TBT_PAD_WORD;
    cnt_hit     = 1'b0;
    evt_next    = 1'b0;
    stop_req    = 1'b0;
    if (!mtest_on_i)
    begin
      case (state_reg)
        tbt_pkg::TBT_IDLE:
        begin
          seen_next   = 1'b0;
          hold_v_next = 1'b0;
          if (trig_count_load_i)
            count_next = trig_count_i;
          if (capture_enable_i)
          begin
            full_next  = 1'b0;
            state_next = tbt_pkg::TBT_CAPTURE;
          end
        end
        tbt_pkg::TBT_CAPTURE:
        begin
          if (mode == tbt_pkg::TBT_FRAMED_CONT && pend_reg != 3'h0)
          begin
            f_we    = 1'b1;
            f_wdata = `TBT_MARKER_WORD;
          end
          else if (fifo_valid && mode == tbt_pkg::TBT_BYPASS)
          begin
            if (hold_v_reg)
            begin
              // flush a held partial word first, zero padded
              f_we        = 1'b1;
              f_wdata     = low_bytes(hold_reg);
              hold_v_next = 1'b0;
            end
            if (fifo_word.valid_bytes != 2'h0)
            begin
              fifo_pop    = 1'b1;
              hold_next   = fifo_word;
              hold_v_next = 1'b1;
            end
            else if (!hold_v_reg)
            begin
              fifo_pop = 1'b1;
              f_we     = 1'b1;
              f_wdata  = fifo_word.data;
            end
          end
          else if (fifo_valid)
          begin
            fifo_pop = 1'b1;
            f_we     = 1'b1;
            f_wdata  = fifo_word.data;
          end
          // countdown of words after the trigger
          if (tin_rise && count_reg != '0)
            seen_next = 1'b1;
          if (f_we && seen_reg && count_reg != '0)
          begin
            count_next = count_reg - 1'b1;
            cnt_hit    = (count_reg == CNT_W'(1));
          end
          evt_next = cnt_hit ||
                     (count_reg == '0 && tin_rise);
          stop_req = cnt_hit || !capture_enable_i ||
                     (flush_done_i && format_flush_control_i.stop_on_flush_enable);
          if (stop_req)
          begin
            state_next = tbt_pkg::TBT_PAD;
            if (mode == tbt_pkg::TBT_BYPASS)
              pad_next = `TBT_BYPASS_PAD;
            else
              // align from the pointer after this cycle's write
              pad_next = {1'b0, 2'(2'h0 - wp_reg[1:0] - {1'b0, f_we})}
                         + `TBT_FRAME_WORDS;
          end
        end
        tbt_pkg::TBT_PAD:
        begin
          fifo_pop = fifo_valid;
          if (mode == tbt_pkg::TBT_FRAMED_CONT && pend_reg != 3'h0)
          begin
            f_we    = 1'b1;
            f_wdata = `TBT_MARKER_WORD;
            // a late marker takes one slot of the closing frame
            if (pad_reg != 3'h0)
              pad_next = pad_reg - 3'h1;
          end
          else if (pad_reg != 3'h0)
          begin
            f_we     = 1'b1;
            pad_next = pad_reg - 3'h1;
            if (mode == tbt_pkg::TBT_BYPASS && hold_v_reg)
            begin
              // marker byte right after the last valid byte
              f_wdata = low_bytes(hold_reg) |
                        (32'(`TBT_POSTAMBLE_BYTE) <<
                         {hold_reg.valid_bytes, 3'h0});
              hold_v_next = 1'b0;
            end
            else if (mode == tbt_pkg::TBT_BYPASS)
              f_wdata = 32'(`TBT_POSTAMBLE_BYTE);
          end
          else
            state_next = tbt_pkg::TBT_DONE;
        end
        tbt_pkg::TBT_DONE:
        begin
          fifo_pop = fifo_valid;                       // discard after stop
          if (!capture_enable_i)
            state_next = tbt_pkg::TBT_IDLE;
        end
        default:
          state_next = tbt_pkg::TBT_IDLE;
      endcase
      if (f_we)
      begin
        wp_next = wp_reg + 1'b1;
        if (wp_next == '0)
          full_next = 1'b1;
      end
    end
    // markers pend per source, set wins over clear
    pend_next = pend_reg;
    if (f_we && f_wdata == `TBT_MARKER_WORD && pend_reg != 3'h0)
      pend_next = pend_reg & (pend_reg - 3'h1);
    if (mode == tbt_pkg::TBT_FRAMED_CONT && state_reg == tbt_pkg::TBT_CAPTURE)
      pend_next = pend_next |
        {evt_next && format_flush_control_i.mark_on_trigger_event_enable,
         flush_done_i && format_flush_control_i.mark_on_flush_done_enable,
         tin_rise && format_flush_control_i.mark_on_trigger_in_enable};
    else if (state_reg == tbt_pkg::TBT_IDLE)
      pend_next = 3'h0;
  end

  // state registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg  <= tbt_pkg::TBT_IDLE;
      wp_reg     <= '0;
      count_reg  <= `TBT_COUNT_RESET;
      seen_reg   <= 1'b0;
      full_reg   <= 1'b0;
      pend_reg   <= 3'h0;
      pad_reg    <= 3'h0;
      hold_reg   <= '0;
      hold_v_reg <= 1'b0;
      evt_reg    <= 1'b0;
      sync1_reg  <= 1'b0;
      sync2_reg  <= 1'b0;
      sync3_reg  <= 1'b0;
      tin_reg    <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      wp_reg     <= wp_next;
      count_reg  <= count_next;
      seen_reg   <= seen_next;
      full_reg   <= full_next;
      pend_reg   <= pend_next;
      pad_reg    <= pad_next;
      hold_reg   <= hold_next;
      hold_v_reg <= hold_v_next;
      evt_reg    <= evt_next;
      sync1_reg  <= trig_in_i;
      sync2_reg  <= sync1_reg;
      sync3_reg  <= sync2_reg;
      tin_reg    <= tin_next;
    end
  end

  // single ram port, bist or functional, always whole words
  always_ff @(posedge sys_clk_i)
  begin
    if (mtest_on_i ? (bist_ce_i && bist_we_i) : f_we)
      ram[mtest_on_i ? bist_addr_i : wp_reg] <=
        mtest_on_i ? bist_din_i : f_wdata;
  end

  // read data registers, each side sees only its own reads
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_reg   <= 32'h0000_0000;
      bist_reg <= 32'h0000_0000;
    end
    else
    begin
      if (!mtest_on_i && rd_en_i)
        rd_reg <= ram[rd_addr_i];
      if (mtest_on_i && bist_ce_i && !bist_we_i)
        bist_reg <= ram[bist_addr_i];
    end
  end

  // outputs
  always_comb
  begin
    rd_data_o         = rd_reg;
    bist_dout_o       = bist_reg;
    trig_event_o      = evt_reg;
    full_o            = full_reg;
    wr_ptr_o          = wp_reg;
    post_count_o      = count_reg;
    capture_stopped_o = (state_reg == tbt_pkg::TBT_DONE);
    acq_complete_o    = capture_stopped_o && count_reg == '0;
  end
endmodule

// ==== rtl/tbt_params.svh ====
// constants of the trace buffer trigger and ram port block
// What this block does
// - trigger event when countdown arrives at zero
// - trigger event when counter zero and trigger-in rises
// - all three marker enables may act together
// - counter counts words still stored after trigger
// - framed modes pad to a frame boundary plus one frame; late markers take pad slots
// - bypass stores at most one extra word
// - markers embedded only with continuous format enabled
// - every ram access is a full word
// - test mode routes bist, blocks functional access
// - bist shares the functional ram port
// - acquisition complete once stopped at zero; full on wrap
// - two control bits choose bypass, framed, continuous
// - bypass stop writes 0x01 then zero bytes
`ifndef TBT_PARAMS_SVH
`define TBT_PARAMS_SVH
`define TBT_FRAME_WORDS     3'h4
`define TBT_MARKER_WORD     32'h7fff_fffe
`define TBT_POSTAMBLE_BYTE  8'h01
`define TBT_PAD_WORD        32'h0000_0000
`define TBT_BYPASS_PAD      3'h1
`define TBT_COUNT_RESET     '0
`endif

// ==== rtl/tbt_pkg.sv ====
// types shared by the trace buffer trigger and ram port block
package tbt_pkg;
  typedef enum logic [1:0] {
    TBT_BYPASS,
    TBT_FRAMED,
    TBT_FRAMED_CONT
  } tbt_mode_type;
  typedef enum logic [1:0] {
    TBT_IDLE,
    TBT_CAPTURE,
    TBT_PAD,
    TBT_DONE
  } tbt_state_type;
  // one trace word; valid_bytes 0 means all four bytes valid
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  valid_bytes;
  } tbt_word_type;
  // format and flush control bits
  typedef struct packed {
    logic mark_on_trigger_event_enable;
    logic mark_on_flush_done_enable;
    logic mark_on_trigger_in_enable;
    logic stop_on_flush_enable;
    logic continuous_format_enable;
    logic frame_format_enable;
  } tbt_format_flush_control_type;
endpackage

// ==== test/tbt_chk.sv ====
// concurrent checks on the trigger, capture and self-test ports
module tbt_chk #(
  parameter int ADDR_W = 10,
  parameter int CNT_W  = 10
) (
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              rst_b_i,
  // control and self-test inputs
  input wire logic              trig_count_load_i,
  input wire logic              mtest_on_i,
  input wire logic              bist_ce_i,
  input wire logic              bist_we_i,
  input wire logic [ADDR_W-1:0] bist_addr_i,
  input wire logic [31:0]       bist_din_i,
  // outputs watched
  input wire logic [31:0]       bist_dout_o,
  input wire logic              trig_event_o,
  input wire logic              acq_complete_o,
  input wire logic              full_o,
  input wire logic              capture_stopped_o,
  input wire logic [ADDR_W-1:0] wr_ptr_o,
  input wire logic [CNT_W-1:0]  post_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // countdown reaching zero raises the trigger event
  a_trig_at_zero: assert property (
    $past(post_count_o) == 1 && post_count_o == 0 |-> ##[0:1] trig_event_o)
    else $error("no trigger event after countdown reached zero");
  a_trig_pulse: assert property (trig_event_o |=> !trig_event_o)
    else $error("trigger event longer than one cycle");
  a_count_holds: assert property (
    post_count_o == 0 && !trig_count_load_i |=> post_count_o == 0)
    else $error("post count left zero without a load");
  a_count_step: assert property (!trig_count_load_i |=>
    post_count_o == $past(post_count_o) ||
    post_count_o == $past(post_count_o) - 1)
    else $error("post count moved by more than one word");
  a_acq_complete: assert property (
    acq_complete_o == (capture_stopped_o && post_count_o == 0))
    else $error("acquisition complete does not match stop and count");
  a_full_wrap: assert property ($rose(full_o) |-> wr_ptr_o == 0)
    else $error("full raised without pointer wrap");
  a_test_freeze: assert property (mtest_on_i |=> $stable(wr_ptr_o))
    else $error("ram written while in test mode");
  a_done_still: assert property (
    capture_stopped_o && $past(capture_stopped_o) |-> $stable(wr_ptr_o))
    else $error("ram written after capture stopped");
  a_bist_echo: assert property (
    mtest_on_i && bist_ce_i && bist_we_i ##1
    mtest_on_i && bist_ce_i && !bist_we_i && $stable(bist_addr_i)
    |=> bist_dout_o == $past(bist_din_i, 2))
    else $error("self-test read did not return written word");

  // main scenarios reached
  c_trig: cover property (trig_event_o);
  c_full: cover property (full_o);
  c_acq: cover property (acq_complete_o);
endmodule

bind tbt_top tbt_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_tbt_chk (
  .sys_clk_i, .rst_b_i, .trig_count_load_i, .mtest_on_i, .bist_ce_i,
  .bist_we_i, .bist_addr_i, .bist_din_i, .bist_dout_o, .trig_event_o,
  .acq_complete_o, .full_o, .capture_stopped_o, .wr_ptr_o, .post_count_o);

// ==== test/tbt_bist_model.sv ====
// memory self-test controller model on the test port
module tbt_bist_model #(
  parameter int ADDR_W = 10
) (
  // clock
  input  wire logic              sys_clk_i,
  // test port
  output logic                   mtest_on_o,
  output logic                   ce_o,
  output logic                   we_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [31:0]       din_o,
  input  wire logic [31:0]       dout_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle test port
  initial
  begin
    mtest_on_o = 1'h0;
    ce_o = 1'h0;
    we_o = 1'h0;
    addr_o = '0;
    din_o = '0;
  end
  // write one word then read it back with the address held
  task automatic echo(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(negedge sys_clk_i);
    mtest_on_o = 1'h1;
    ce_o = 1'h1;
    we_o = 1'h1;
    addr_o = a;
    din_o = d;
    @(negedge sys_clk_i);
    we_o = 1'h0;
    @(negedge sys_clk_i);
    q = dout_i;
    ce_o = 1'h0;
    addr_o = ~a; // released lines lose their last value
    din_o = ~d;
    @(negedge sys_clk_i);
    mtest_on_o = 1'h0;
  endtask
endmodule

// ==== test/trace_buffer_trigger_ram_tb.sv ====
// testbench for the trace buffer trigger and ram port block
module trace_buffer_trigger_ram_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 4;
  logic sys_clk_i = 1'h0, rst_b_i = 1'h0, trace_valid_i = 1'h0;
  logic capture_enable_i = 1'h0, trig_count_load_i = 1'h0;
  logic flush_done_i = 1'h0, trig_in_i = 1'h0, rd_en_i = 1'h0;
  tbt_pkg::tbt_word_type trace_i = '0;
  tbt_pkg::tbt_format_flush_control_type format_flush_control_i = '0;
  logic [9:0] trig_count_i = '0, post_count_o;
  logic [AW-1:0] rd_addr_i = '0, wr_ptr_o, bist_addr_i, p;
  logic trace_ready_o, trig_event_o, acq_complete_o, full_o;
  logic capture_stopped_o, mtest_on_i, bist_ce_i, bist_we_i;
  logic [31:0] rd_data_o, bist_din_i, bist_dout_o, q;
  int miscompares = 0, cmp_count = 0, n_ev = 0, pad;

  always #10 sys_clk_i = ~sys_clk_i;
  // count trigger event pulses
  always @(negedge sys_clk_i) if (trig_event_o === 1'h1) n_ev++;

  tbt_top #(.ADDR_W(AW), .CNT_W(10), .FIFO_DEPTH(16)) u_tbt_top (
    .sys_clk_i, .rst_b_i, .trace_i, .trace_valid_i, .trace_ready_o,
    .format_flush_control_i, .capture_enable_i, .trig_count_load_i,
    .trig_count_i, .flush_done_i, .trig_in_i, .trig_event_o,
    .acq_complete_o, .full_o, .capture_stopped_o, .wr_ptr_o, .post_count_o,
    .rd_en_i, .rd_addr_i, .rd_data_o, .mtest_on_i, .bist_ce_i, .bist_we_i,
    .bist_addr_i, .bist_din_i, .bist_dout_o);
  tbt_bist_model #(.ADDR_W(AW)) u_tbt_bist_model (
    .sys_clk_i, .mtest_on_o(mtest_on_i), .ce_o(bist_ce_i), .we_o(bist_we_i),
    .addr_o(bist_addr_i), .din_o(bist_din_i), .dout_i(bist_dout_o));

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // bounded wait for a flag: 0 fifo ready, 1 capture stopped
  task automatic await(input int sel);
    int i;
    i = 0;
    while (i < 60 && (sel == 0 ? trace_ready_o : capture_stopped_o) !== 1'h1)
    begin
      @(negedge sys_clk_i);
      i++;
    end
    if (i == 60)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // offer one word until taken; valid stays up for the next one
  task automatic push(input logic [31:0] d, input logic [1:0] vb);
    trace_i = '{data: d, valid_bytes: vb};
    trace_valid_i = 1'h1;
    await(0);
    @(negedge sys_clk_i);
  endtask
  // functional read, one cycle latency
  task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
    rd_en_i = 1'h1;
    rd_addr_i = a;
    @(negedge sys_clk_i);
    d = rd_data_o;
    rd_en_i = 1'h0;
    @(negedge sys_clk_i);
  endtask
  // fresh rising edge on the trigger input, past the filter
  task automatic rise();
    trig_in_i = 1'h0;
    cyc(6);
    trig_in_i = 1'h1;
    cyc(12);
  endtask

  initial
  begin
    cyc(16);
    rst_b_i = 1'h1;
    // fill fifo while idle until it refuses
    for (int k = 0; k < 16; k++) push(32'h1000_0000 + k, 2'h0);
    trace_valid_i = 1'h0;
    chk(trace_ready_o, 32'h0);
    // bypass capture drains sixteen words and wraps
    trig_count_i = 10'h3;
    trig_count_load_i = 1'h1;
    cyc(1);
    trig_count_load_i = 1'h0;
    capture_enable_i = 1'h1;
    cyc(30);
    chk(full_o, 32'h1);
    chk(wr_ptr_o, 32'h0);
    rise();
    chk(post_count_o, 32'h3);
    for (int k = 0; k < 3; k++) push(32'ha5a5_0000 + k, 2'h0);
    trace_valid_i = 1'h0;
    await(1);
    chk(n_ev, 32'h1);
    chk(post_count_o, 32'h0);
    chk(acq_complete_o, 32'h1);
    chk(wr_ptr_o, 32'h4);
    rd(4'h3, q);
    chk(q, 32'h0000_0001);
    rd(4'h2, q);
    chk(q, 32'ha5a5_0002);
    // framed continuous capture with three marker sources
    capture_enable_i = 1'h0;
    cyc(3);
    format_flush_control_i = 6'h3b;
    capture_enable_i = 1'h1;
    cyc(3);
    p = wr_ptr_o;
    rise();
    chk(n_ev, 32'h2);
    flush_done_i = 1'h1;
    cyc(1);
    flush_done_i = 1'h0;
    cyc(4);
    chk(wr_ptr_o, p + 32'h3);
    rd(p, q);
    chk(q, 32'h7fff_fffe);
    // framed only: no marker, no stop
    format_flush_control_i.continuous_format_enable = 1'h0;
    rise();
    chk(wr_ptr_o, p + 32'h3);
    chk(capture_stopped_o, 32'h0);
    capture_enable_i = 1'h0;
    await(1);
    pad = (4 - (p + 3) % 4) % 4 + 4;
    chk(wr_ptr_o, p + 32'h3 + pad);
    // self-test write and readback through the ram port
    u_tbt_bist_model.echo(4'h5, 32'hc3c3_5a5a, q);
    chk(q, 32'hc3c3_5a5a);
    chk(wr_ptr_o, p + 32'h3 + pad);
    // bypass partial word: stray lanes dropped, end byte merged
    format_flush_control_i = '0;
    capture_enable_i = 1'h1;
    cyc(2);
    p = wr_ptr_o;
    push(32'hee00_b2c7, 2'h2);
    trace_valid_i = 1'h0;
    cyc(3);
    capture_enable_i = 1'h0;
    await(1);
    chk(wr_ptr_o, p + 32'h1);
    rd(p, q);
    chk(q, 32'h0001_b2c7);
    report_and_stop();
  end
endmodule
